// [include/asc_defs.svh]
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH

// Memory geometry
`define ASC_ADDR_W        13
`define ASC_DATA_W        8

// Clock period and fastest-grade access time, in ns
`define ASC_CLK_NS        8
`define ASC_ACCESS_NS     15

// Write strobe low time and address setup margin, in ns
`define ASC_WRITE_NS      15
`define ASC_SETUP_NS      1

// Derived cycle counts: least times round up
`define ASC_ACCESS_CYC    ((`ASC_ACCESS_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_WRITE_CYC     ((`ASC_WRITE_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_SETUP_CYC     ((`ASC_SETUP_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)

// Synchroniser stages on the data lines, added to every read wait
`define ASC_SYNC_CYC      2

// Counter width
`define ASC_CNT_W         4

`endif

// [include/asc_pkg.sv]
`include "asc_defs.svh"

package asc_pkg;

  // Request from the user side
  typedef struct packed {
    logic                     wr;
    logic [`ASC_ADDR_W-1:0]   addr;
    logic [`ASC_DATA_W-1:0]   wdata;
  } asc_req_t;

  // Pin outputs towards the memory
  typedef struct packed {
    logic                     sel_low_n;
    logic                     sel_high;
    logic                     oe_n;
    logic                     we_n;
    logic [`ASC_ADDR_W-1:0]   addr;
  } asc_pins_t;

  // Controller states
  typedef enum logic [2:0] {
    ASC_IDLE  = 3'b000,
    ASC_RSET  = 3'b001,
    ASC_RWAIT = 3'b010,
    ASC_WSET  = 3'b011,
    ASC_WPULS = 3'b100,
    ASC_WHOLD = 3'b101
  } asc_state_t;

endpackage

// [rtl/asc_timer.sv]
`timescale 1ns/1ps
`include "asc_defs.svh"

// Down counter that flags when a phase has lasted its cycle count
module asc_timer
  import asc_pkg::*;
#(
  parameter int CW = `ASC_CNT_W
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          load,
  input  wire logic [CW-1:0] count,
  output logic               done
);

  logic [CW-1:0] cnt_q;   // Remaining cycles
  logic [CW-1:0] cnt_d;

  ////////////////////////////////////////////////////////////////////////
  // Next count
  always_comb begin
    if (load) begin
      cnt_d = count;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CW'(1);
    end else begin
      cnt_d = cnt_q;
    end
  end

  // Register
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Done when one cycle is left, so phases last exactly 'count' cycles
  assign done = (cnt_q == CW'(1));

endmodule

// [rtl/asc_ctrl.sv]
`timescale 1ns/1ps
`include "asc_defs.svh"

// Behaviour
// - Selected only: select-low low, select-high high
// - Write ends on first rising select/strobe
// - Hold write data around terminating edge
// - Read: strobe high, selected, enable low
// - Address change updates data after access time
// - Address valid before select-low falls
module asc_ctrl
  import asc_pkg::*;
#(
  parameter int AW = `ASC_ADDR_W,
  parameter int DW = `ASC_DATA_W
) (
  input  wire logic          SYS_CLK,
  input  wire logic          RESET,
  input  wire logic          REQ_VALID,
  output logic               REQ_READY,
  input  wire asc_req_t      REQ,
  output logic               RD_VALID,
  output logic [DW-1:0]      RD_DATA,
  output logic               WR_DONE,
  output asc_pins_t          MEM_PINS,
  output logic [DW-1:0]      DATA_LINES_O,
  output logic               DATA_LINES_OE_N,
  input  wire logic [DW-1:0] DATA_LINES_I
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  asc_state_t         st_q, st_d;          // Sequencer state
  asc_pins_t          pins_q, pins_d;      // Registered pin levels
  logic [DW-1:0]      wdat_q, wdat_d;      // Write data held on the lines
  logic               drv_q, drv_d;        // Host drives data lines
  logic [DW-1:0]      rdat_q, rdat_d;      // Captured read word
  logic               rvld_q, rvld_d;      // Read answer pulse
  logic               wdone_q, wdone_d;    // Write answer pulse
  logic [DW-1:0]      sync1_q, sync2_q;    // Data line synchroniser
  logic               tload;               // Start a timed phase
  logic [`ASC_CNT_W-1:0] tcount;           // Length of that phase
  logic               tdone;               // Phase elapsed

  ////////////////////////////////////////////////////////////////////////
  // Phase timer
  asc_timer #(.CW(`ASC_CNT_W)) u_timer (
    .clk   (SYS_CLK),
    .rst   (RESET),
    .load  (tload),
    .count (tcount),
    .done  (tdone)
  );

  ////////////////////////////////////////////////////////////////////////
  // Data lines are asynchronous to us: two flops before use
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= DATA_LINES_I;
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    st_d    = st_q;
    pins_d  = pins_q;
    wdat_d  = wdat_q;
    drv_d   = drv_q;
    rdat_d  = rdat_q;
    rvld_d  = 1'b0;
    wdone_d = 1'b0;
    tload   = 1'b0;
    tcount  = '0;
    case (st_q)
      ASC_IDLE: begin
        // Deselected and idle lets the memory power down
        pins_d.sel_low_n = 1'b1;
        pins_d.sel_high  = 1'b0;
        pins_d.oe_n      = 1'b1;
        pins_d.we_n      = 1'b1;
        drv_d            = 1'b0;
        if (REQ_VALID) begin
          // Address placed before select falls
          pins_d.addr = REQ.addr;
          tload       = 1'b1;
          tcount      = `ASC_CNT_W'(`ASC_SETUP_CYC);
          if (REQ.wr) begin
            wdat_d = REQ.wdata;
            drv_d  = 1'b1;
            st_d   = ASC_WSET;
          end else begin
            st_d   = ASC_RSET;
          end
        end
      end
      ASC_RSET: begin
        // Select, keep strobe high, enable outputs
        pins_d.sel_low_n = 1'b0;
        pins_d.sel_high  = 1'b1;
        pins_d.oe_n      = 1'b0;
        pins_d.we_n      = 1'b1;
        tload            = 1'b1;
        // Extra cycles cover the two synchroniser stages
        tcount = `ASC_CNT_W'(`ASC_ACCESS_CYC + `ASC_SYNC_CYC);
        st_d   = ASC_RWAIT;
      end
      ASC_RWAIT: begin
        if (tdone) begin
          rdat_d = sync2_q;
          rvld_d = 1'b1;
          st_d   = ASC_IDLE;
        end
      end
      ASC_WSET: begin
        if (tdone) begin
          // Output enable kept high so the memory floats
          pins_d.oe_n      = 1'b1;
          pins_d.sel_low_n = 1'b0;
          pins_d.sel_high  = 1'b1;
          pins_d.we_n      = 1'b0;
          tload            = 1'b1;
          tcount           = `ASC_CNT_W'(`ASC_WRITE_CYC);
          st_d             = ASC_WPULS;
        end
      end
      ASC_WPULS: begin
        if (tdone) begin
          // Strobe rises first: strobe-controlled write
          pins_d.we_n = 1'b1;
          st_d        = ASC_WHOLD;
        end
      end
      ASC_WHOLD: begin
        // Data and address still held one cycle past the edge
        pins_d.sel_low_n = 1'b1;
        pins_d.sel_high  = 1'b0;
        drv_d            = 1'b0;
        wdone_d          = 1'b1;
        st_d             = ASC_IDLE;
      end
      default: begin
        st_d = ASC_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer registers
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      st_q    <= ASC_IDLE;
      pins_q  <= '{sel_low_n: 1'b1, sel_high: 1'b0, oe_n: 1'b1, we_n: 1'b1, addr: '0};
      wdat_q  <= '0;
      drv_q   <= 1'b0;
      rdat_q  <= '0;
      rvld_q  <= 1'b0;
      wdone_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      pins_q  <= pins_d;
      wdat_q  <= wdat_d;
      drv_q   <= drv_d;
      rdat_q  <= rdat_d;
      rvld_q  <= rvld_d;
      wdone_q <= wdone_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; memory is static, so no refresh path exists
  assign REQ_READY       = (st_q == ASC_IDLE);
  assign RD_VALID        = rvld_q;
  assign RD_DATA         = rdat_q;
  assign WR_DONE         = wdone_q;
  assign MEM_PINS        = pins_q;
  assign DATA_LINES_O    = wdat_q;
  assign DATA_LINES_OE_N = ~drv_q;

endmodule

// [verification/asc_sram_model.sv]
`timescale 1ns/1ps
// Behavioural byte-wide static memory on the far side of the pins
module asc_sram_model
  import asc_pkg::*;
(
  input  wire asc_pins_t  pins,
  input  wire logic [7:0] data_lines,
  output logic [7:0]      q,
  output logic            drv
);
  logic [7:0] mem [0:8191]; // No clock, no refresh
  logic       sel;          // Both selects active
  logic       wr_act;       // Select and strobe overlap
  logic       low_power;    // Standby flag, not modelled further
  assign sel = !pins.sel_low_n && pins.sel_high;
  assign low_power = !sel;
  assign wr_act = sel && !pins.we_n;
  assign drv = sel && !pins.oe_n && pins.we_n;
  // Word lags address by the access time; early looks stay stale
  assign #15 q = mem[pins.addr];
  // First rising select or strobe captures the data
  always @(negedge wr_act) mem[pins.addr] = data_lines;
endmodule

// [verification/asc_ctrl_monitor.sv]
`timescale 1ns/1ps
// Pin sequencing checks, from the controller ports only
module asc_ctrl_check
  import asc_pkg::*;
(
  input wire logic       SYS_CLK,
  input wire logic       RESET,
  input wire logic       REQ_VALID,
  input wire logic       REQ_READY,
  input wire asc_req_t   REQ,
  input wire logic       RD_VALID,
  input wire logic       WR_DONE,
  input wire asc_pins_t  MEM_PINS,
  input wire logic [7:0] DATA_LINES_O,
  input wire logic       DATA_LINES_OE_N
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  logic take; // Request accepted this edge
  assign take = REQ_VALID && REQ_READY;
  a_write_latency: assert property (take && REQ.wr |-> ##5 WR_DONE)
    else $error("write done late");
  a_read_latency: assert property (take && !REQ.wr |-> ##6 RD_VALID)
    else $error("read data late");
  a_answer_single: assert property ((RD_VALID || WR_DONE) |=> !RD_VALID && !WR_DONE)
    else $error("answer held too long");
  a_strobe_width: assert property ($fell(MEM_PINS.we_n) |=> !MEM_PINS.we_n ##1 MEM_PINS.we_n)
    else $error("strobe width wrong");
  a_write_hold: assert property (!MEM_PINS.we_n |=> $stable(DATA_LINES_O)
    && $stable(MEM_PINS.addr) && !MEM_PINS.sel_low_n && !DATA_LINES_OE_N)
    else $error("write not held");
  a_write_pins: assert property (!MEM_PINS.we_n |-> !MEM_PINS.sel_low_n
    && MEM_PINS.sel_high && MEM_PINS.oe_n && !DATA_LINES_OE_N)
    else $error("write pins wrong");
  a_read_pins: assert property (!MEM_PINS.oe_n |-> MEM_PINS.we_n
    && !MEM_PINS.sel_low_n && MEM_PINS.sel_high && DATA_LINES_OE_N)
    else $error("read pins wrong");
  a_addr_first: assert property ($fell(MEM_PINS.sel_low_n) |-> $stable(MEM_PINS.addr))
    else $error("address moved at select");
  a_idle_float: assert property (REQ_READY |-> DATA_LINES_OE_N && MEM_PINS.we_n)
    else $error("idle lines driven");
  c_read: cover property (take && !REQ.wr);
  c_write: cover property (take && REQ.wr);
  c_back: cover property ((RD_VALID || WR_DONE) && take);
endmodule
bind asc_ctrl asc_ctrl_check chk_u (.SYS_CLK, .RESET, .REQ_VALID, .REQ_READY, .REQ,
  .RD_VALID, .WR_DONE, .MEM_PINS, .DATA_LINES_O, .DATA_LINES_OE_N);

// [verification/tb_async_sram_8k_x8_port.sv]
`timescale 1ns/1ps
`include "asc_defs.svh"
// Controller driving the behavioural memory; rows first, then edge cases
module tb_async_sram_8k_x8_port
  import asc_pkg::*;
;
  logic       SYS_CLK = 1'b0;
  logic       RESET = 1'b1;
  logic       REQ_VALID = 1'b0;
  asc_req_t   REQ = '0;
  asc_pins_t  MEM_PINS;
  logic       REQ_READY, RD_VALID, WR_DONE, DATA_LINES_OE_N, mem_drv;
  logic [7:0] RD_DATA, DATA_LINES_O, DATA_LINES_I, mem_q;
  logic [7:0] last_q = 8'h00; // Last level seen on the lines
  int         errors = 0;
  int         samples_checked = 0;
  // Writes at both ends of the space, then reads expecting wdata
  localparam asc_req_t rows [6] = '{'{1'b1, 13'h0000, 8'ha5}, '{1'b1, 13'h1fff, 8'h3c},
    '{1'b1, 13'h0001, 8'h5a}, '{1'b0, 13'h0000, 8'ha5}, '{1'b0, 13'h1fff, 8'h3c},
    '{1'b0, 13'h0001, 8'h5a}};
  always #4 SYS_CLK = ~SYS_CLK;
  // Undriven lines show the inverse, so a stale word cannot pass
  assign DATA_LINES_I = !DATA_LINES_OE_N ? DATA_LINES_O : mem_drv ? mem_q : ~last_q;
  always @(posedge SYS_CLK) last_q <= DATA_LINES_I;
  asc_ctrl dut_u (.SYS_CLK, .RESET, .REQ_VALID, .REQ_READY, .REQ, .RD_VALID, .RD_DATA,
    .WR_DONE, .MEM_PINS, .DATA_LINES_O, .DATA_LINES_OE_N, .DATA_LINES_I);
  asc_sram_model mem_u (.pins(MEM_PINS), .data_lines(DATA_LINES_I), .q(mem_q), .drv(mem_drv));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One request, held until taken, then wait for its answer
  task automatic do_op(input asc_req_t r);
    int n;
    n = 0;
    REQ = r;
    REQ_VALID = 1'b1;
    // Ready read settled at the falling edge; taken at the next rise
    while (REQ_READY !== 1'b1) @(negedge SYS_CLK);
    @(posedge SYS_CLK);
    @(negedge SYS_CLK) REQ_VALID = 1'b0;
    while (RD_VALID !== 1'b1 && WR_DONE !== 1'b1 && n < 20) begin
      @(negedge SYS_CLK);
      n++;
    end
    chk("answer_wait", 0, n == 20);
    chk("answer_kind", r.wr ? 32'h1 : 32'h2, {RD_VALID, WR_DONE});
    chk("latency", r.wr ? `ASC_SETUP_CYC + `ASC_WRITE_CYC + 1 : `ASC_SETUP_CYC + `ASC_ACCESS_CYC + `ASC_SYNC_CYC, n);
  endtask
  task automatic close_out();
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Both parties never drive the lines at once
  always @(negedge SYS_CLK) if (RESET === 1'b0) chk("contention", 0, !DATA_LINES_OE_N && mem_drv);
  // Watchdog: far beyond the hundred or fewer cycles the tests need
  initial begin
    #200000;
    errors++;
    close_out();
  end
  initial begin
    repeat (12) @(negedge SYS_CLK);
    chk("reset_pins", {1'b1, 1'b0, 1'b1, 1'b1, 13'h0}, MEM_PINS);
    RESET = 1'b0;
    for (int i = 0; i < 6; i++) begin
      do_op(rows[i]);
      if (!rows[i].wr) chk("rd_data", rows[i].wdata, RD_DATA);
    end
    // Back-to-back overwrite, read, and a write that must not touch RD_DATA
    do_op('{1'b1, 13'h1fff, 8'hc3});
    do_op('{1'b0, 13'h1fff, 8'h00});
    chk("rd_again", 8'hc3, RD_DATA);
    do_op('{1'b1, 13'h0002, 8'h77});
    chk("rd_stands", 8'hc3, RD_DATA);
    // Reset in mid-read: pins let go at the next rising edge and no answer follows
    REQ = '{1'b0, 13'h0002, 8'h00};
    REQ_VALID = 1'b1;
    while (REQ_READY !== 1'b1) @(negedge SYS_CLK);
    @(posedge SYS_CLK);
    @(negedge SYS_CLK) REQ_VALID = 1'b0;
    @(negedge SYS_CLK) RESET = 1'b1;
    repeat (2) @(negedge SYS_CLK);
    chk("reset_pins_mid", {1'b1, 1'b0, 1'b1, 1'b1, 13'h0}, MEM_PINS);
    chk("ready_mid", 1, REQ_READY);
    chk("no_answer", 0, RD_VALID);
    RESET = 1'b0;
    // Static memory keeps its word through a controller reset
    do_op('{1'b0, 13'h0002, 8'h00});
    chk("rd_after_reset", 8'h77, RD_DATA);
    close_out();
  end
endmodule
